// file: uvfh_top.sv
/*
  Output undervoltage supervision: thresholds, warning flag and fault action.
  Assumes command strobes and measurements come from same-clock logic;
  the remote control pin is synchronised here.
*/
`timescale 1ns/1ns
`default_nettype none
module uvfh_top
  import uvfh_pkg::*;
(
  input wire logic CLK,
  input wire logic SYS_RST,
  input wire logic CMD_WR,
  input wire logic CMD_RD,
  input wire logic [7:0] CMD_CODE,
  input wire logic [15:0] CMD_WDATA,
  output logic [15:0] CMD_RDATA,
  output logic CMD_RVALID,
  input wire logic CLEAR_STATUS,
  input wire logic CLEAR_ALL,
  input wire logic CMD_OFF,
  input wire logic CTRL_PIN_OFF,
  input wire logic [UVFH_UNIT_W-1:0] UNIT_CLKS,
  input wire logic MEAS_VALID,
  input wire logic [15:0] MEAS_VOUT,
  output logic OUT_ENABLE,
  output logic UV_WARN,
  output logic UV_FAULT,
  output logic UV_LATCHED
);

  typedef struct packed {
    uvfh_state_t st;
    logic [2:0] tries;
    logic warn;
    logic fault_now;
    logic latched;
    logic en;
    logic [1:0] ctrl_sync;
    logic off_prev;
  } uvfh_top_st_t;

  uvfh_top_st_t s_reg, s_next;
  uvfh_req_t req;
  logic [15:0] warn_thr;
  logic [15:0] fault_thr;
  logic [7:0] action;
  logic [1:0] resp;
  logic [2:0] retry;
  logic [2:0] dly;
  logic tmr_start;
  logic tmr_done;
  logic below_fault;
  logic off_req;
  logic off_release;
  logic retry_left;

  assign req = '{wr: CMD_WR, rd: CMD_RD, cmd: CMD_CODE, wdata: CMD_WDATA};

  uvfh_regs u_regs (
    .clk(CLK),
    .rst(SYS_RST),
    .req(req),
    .warn_thr(warn_thr),
    .fault_thr(fault_thr),
    .action(action),
    .rdata(CMD_RDATA),
    .rvalid(CMD_RVALID)
  );

  uvfh_timer u_timer (
    .clk(CLK),
    .rst(SYS_RST),
    .start(tmr_start),
    .dly_code(dly),
    .unit_clks(UNIT_CLKS),
    .done(tmr_done)
  );

  assign resp = action[UVFH_RESP_MSB:UVFH_RESP_LSB];
  assign retry = action[UVFH_RETRY_MSB:UVFH_RETRY_LSB];
  assign dly = action[UVFH_DLY_MSB:UVFH_DLY_LSB];
  assign below_fault = MEAS_VALID ? (MEAS_VOUT < fault_thr) : s_reg.fault_now;
  assign off_req = CMD_OFF | s_reg.ctrl_sync[1];
  assign off_release = s_reg.off_prev & ~off_req;
  assign retry_left = (retry == UVFH_RETRY_FOREVER) || (s_reg.tries < retry);

  // ==========================================================
  // Fault response sequencer
  always_comb begin
    s_next = s_reg;
    tmr_start = 1'b0;
    s_next.ctrl_sync = {s_reg.ctrl_sync[0], CTRL_PIN_OFF};
    s_next.off_prev = off_req;
    s_next.fault_now = below_fault;
    if (MEAS_VALID) begin
      s_next.warn = (MEAS_VOUT < warn_thr) | (s_reg.warn & ~CLEAR_STATUS & ~CLEAR_ALL);
    end else if (CLEAR_STATUS | CLEAR_ALL) begin
      s_next.warn = 1'b0;
    end
    unique case (s_reg.st)
      UVFH_RUN: begin
        s_next.en = ~off_req;
        if (below_fault && !off_req) begin
          unique case (resp)
            UVFH_RESP_IGNORE: ;
            UVFH_RESP_RIDE: begin
              s_next.st = UVFH_RIDE;
              tmr_start = 1'b1;
            end
            UVFH_RESP_SHUT: begin
              s_next.en = 1'b0;
              s_next.tries = 3'h0;
              s_next.latched = 1'b1;
              s_next.st = (retry == UVFH_RETRY_NONE) ? UVFH_LATCHED : UVFH_OFFWAIT;
              tmr_start = 1'b1;
            end
            UVFH_RESP_HOLD: begin
              s_next.en = 1'b0;
              s_next.st = UVFH_OFFWAIT;
            end
          endcase
        end
      end
      UVFH_RIDE: begin
        if (tmr_done) begin
          s_next.tries = 3'h0;
          if (below_fault) begin
            s_next.en = 1'b0;
            s_next.latched = 1'b1;
            s_next.st = (retry == UVFH_RETRY_NONE) ? UVFH_LATCHED : UVFH_OFFWAIT;
            tmr_start = 1'b1;
          end else begin
            s_next.st = UVFH_RUN;
          end
        end
      end
      UVFH_OFFWAIT: begin
        if (resp == UVFH_RESP_HOLD) begin
          if (!below_fault) begin
            s_next.en = 1'b1;
            s_next.st = UVFH_RUN;
          end
        end else if (tmr_done) begin
          if (retry_left) begin
            s_next.en = 1'b1;
            s_next.tries = (retry == UVFH_RETRY_FOREVER) ? 3'h0 : s_reg.tries + 3'h1;
            s_next.st = UVFH_RESTART;
            tmr_start = 1'b1;
          end else begin
            s_next.st = UVFH_LATCHED;
          end
        end
      end
      UVFH_RESTART: begin
        if (below_fault) begin
          s_next.en = 1'b0;
          s_next.st = UVFH_OFFWAIT;
        end else if (tmr_done) begin
          s_next.latched = 1'b0;
          s_next.st = UVFH_RUN;
        end
      end
      UVFH_LATCHED: begin
        s_next.en = 1'b0;
      end
      default: s_next.st = UVFH_RUN;
    endcase
    if (off_req && s_reg.st != UVFH_RUN) begin
      s_next.en = 1'b0;
    end
    if ((CLEAR_STATUS | CLEAR_ALL | off_release) && s_reg.latched) begin
      s_next.latched = 1'b0;
      s_next.st = UVFH_RUN;
      s_next.en = ~off_req;
      s_next.tries = 3'h0;
    end
  end

  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      s_reg <= '{st: UVFH_RUN, tries: 3'h0, warn: 1'b0, fault_now: 1'b0, latched: 1'b0,
                 en: 1'b0, ctrl_sync: 2'h0, off_prev: 1'b0};
    end else begin
      s_reg <= s_next;
    end
  end

  assign OUT_ENABLE = s_reg.en;
  assign UV_WARN = s_reg.warn;
  assign UV_FAULT = s_reg.fault_now;
  assign UV_LATCHED = s_reg.latched;

  // ==========================================================
  // Checks
  chk_ignore_runs: assert property (@(posedge CLK) disable iff (SYS_RST)
    s_reg.st == UVFH_RUN && resp == UVFH_RESP_IGNORE && !off_req |=> OUT_ENABLE)
    else $error("ignore mode dropped output");
  chk_shut_immediate: assert property (@(posedge CLK) disable iff (SYS_RST)
    s_reg.st == UVFH_RUN && resp == UVFH_RESP_SHUT && below_fault |=> !OUT_ENABLE)
    else $error("shutdown not immediate");
  chk_ride_keeps: assert property (@(posedge CLK) disable iff (SYS_RST)
    s_reg.st == UVFH_RIDE && !tmr_done && !off_req |=> OUT_ENABLE)
    else $error("output lost during ride-through");
  chk_hold_resume: assert property (@(posedge CLK) disable iff (SYS_RST)
    s_reg.st == UVFH_OFFWAIT && resp == UVFH_RESP_HOLD && !below_fault && !off_req
    |=> OUT_ENABLE)
    else $error("hold mode did not resume");
  chk_latched_off: assert property (@(posedge CLK) disable iff (SYS_RST)
    s_reg.st == UVFH_LATCHED |-> !OUT_ENABLE)
    else $error("output on while latched");
  chk_clear_latch: assert property (@(posedge CLK) disable iff (SYS_RST)
    s_reg.latched && CLEAR_ALL |=> !UV_LATCHED)
    else $error("clear did not release latch");
  chk_retry_bound: assert property (@(posedge CLK) disable iff (SYS_RST)
    retry != UVFH_RETRY_FOREVER && s_reg.st == UVFH_RESTART |-> s_reg.tries <= retry)
    else $error("too many restart attempts");
  chk_one_retry: assert property (@(posedge CLK) disable iff (SYS_RST)
    s_reg.st == UVFH_OFFWAIT && retry == 3'h1 && s_reg.tries == 3'h1 && tmr_done
    && resp != UVFH_RESP_HOLD && !CLEAR_ALL && !CLEAR_STATUS && !off_release
    |=> s_reg.st == UVFH_LATCHED)
    else $error("second attempt after single retry");
  chk_warn_flag: assert property (@(posedge CLK) disable iff (SYS_RST)
    MEAS_VALID && MEAS_VOUT < warn_thr |=> UV_WARN)
    else $error("warning flag not set");


  // ==========================================================
  // Sequencer checks
  chk_warn_clear: assert property (@(posedge CLK) disable iff (SYS_RST)
    !MEAS_VALID && (CLEAR_STATUS || CLEAR_ALL)
    |=> !UV_WARN)
    else $error("warning flag not cleared");

  chk_hold_off: assert property (@(posedge CLK) disable iff (SYS_RST)
    s_reg.st == UVFH_RUN && resp == UVFH_RESP_HOLD && below_fault
    |=> !OUT_ENABLE)
    else $error("hold mode left output on");

  chk_restart_en: assert property (@(posedge CLK) disable iff (SYS_RST)
    s_reg.st == UVFH_OFFWAIT && resp != UVFH_RESP_HOLD && tmr_done && retry_left && !off_req
    |=> OUT_ENABLE)
    else $error("restart attempt missing");

  chk_restart_fail: assert property (@(posedge CLK) disable iff (SYS_RST)
    s_reg.st == UVFH_RESTART && below_fault && !CLEAR_STATUS && !CLEAR_ALL && !off_release
    |=> !OUT_ENABLE)
    else $error("failed restart left output on");

  chk_retry_none: assert property (@(posedge CLK) disable iff (SYS_RST)
    s_reg.st == UVFH_RUN && resp == UVFH_RESP_SHUT && below_fault && !off_req
    && retry == UVFH_RETRY_NONE |=> s_reg.st == UVFH_LATCHED)
    else $error("restart without retries");

  chk_fault_flag: assert property (@(posedge CLK) disable iff (SYS_RST)
    MEAS_VALID
    |=> UV_FAULT == $past(MEAS_VOUT < fault_thr))
    else $error("fault flag wrong");

  chk_off_disables: assert property (@(posedge CLK) disable iff (SYS_RST)
    off_req
    |=> !OUT_ENABLE)
    else $error("output on while commanded off");

  chk_ignore_fault: assert property (@(posedge CLK) disable iff (SYS_RST)
    s_reg.st == UVFH_RUN && resp == UVFH_RESP_IGNORE && below_fault
    |=> s_reg.st == UVFH_RUN)
    else $error("ignore mode left run state");

  cov_forever: cover property (@(posedge CLK) retry == UVFH_RETRY_FOREVER && s_reg.st == UVFH_RESTART);
  cov_ride: cover property (@(posedge CLK) s_reg.st == UVFH_RIDE ##1 s_reg.st == UVFH_OFFWAIT);
  cov_restart: cover property (@(posedge CLK) s_reg.st == UVFH_RESTART ##1 s_reg.st == UVFH_RUN);
  cov_latch: cover property (@(posedge CLK) s_reg.st == UVFH_LATCHED);
  cov_hold: cover property (@(posedge CLK) resp == UVFH_RESP_HOLD && s_reg.st == UVFH_OFFWAIT);

endmodule
`default_nettype wire

// file: uvfh_pkg.sv
/*
  Package for the output undervoltage fault handling block.
  Assumes a command-code register port driven by the management interface logic.
*/
package uvfh_pkg;

  // ==========================================================
  // Register map
  localparam logic [7:0] UVFH_OFS_WARN = 8'h43;
  localparam logic [7:0] UVFH_OFS_FAULT = 8'h44;
  localparam logic [7:0] UVFH_OFS_ACTION = 8'h45;
  localparam logic [15:0] UVFH_RST_WARN = 16'h0000;
  localparam logic [15:0] UVFH_RST_FAULT = 16'h0000;
  localparam logic [7:0] UVFH_RST_ACTION = 8'h00;

  // ==========================================================
  // Action field positions
  localparam int UVFH_RESP_MSB = 7;
  localparam int UVFH_RESP_LSB = 6;
  localparam int UVFH_RETRY_MSB = 5;
  localparam int UVFH_RETRY_LSB = 3;
  localparam int UVFH_DLY_MSB = 2;
  localparam int UVFH_DLY_LSB = 0;

  localparam logic [1:0] UVFH_RESP_IGNORE = 2'h0;
  localparam logic [1:0] UVFH_RESP_RIDE = 2'h1;
  localparam logic [1:0] UVFH_RESP_SHUT = 2'h2;
  localparam logic [1:0] UVFH_RESP_HOLD = 2'h3;
  localparam logic [2:0] UVFH_RETRY_NONE = 3'h0;
  localparam logic [2:0] UVFH_RETRY_FOREVER = 3'h7;

  localparam int UVFH_UNIT_W = 16;
  localparam int UVFH_TMR_W = UVFH_UNIT_W + 8;

  typedef enum logic [4:0] {
    UVFH_RUN = 5'h01,
    UVFH_RIDE = 5'h02,
    UVFH_OFFWAIT = 5'h04,
    UVFH_RESTART = 5'h08,
    UVFH_LATCHED = 5'h10
  } uvfh_state_t;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] cmd;
    logic [15:0] wdata;
  } uvfh_req_t;

  typedef struct packed {
    logic clear_status;
    logic clear_all;
    logic ctrl_off;
  } uvfh_clr_t;

endpackage

// file: uvfh_regs.sv
/*
  Threshold and action registers of the undervoltage block.
  Assumes one request per cycle from same-clock command logic.
*/
`timescale 1ns/1ns
`default_nettype none
module uvfh_regs
  import uvfh_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire uvfh_req_t req,
  output logic [15:0] warn_thr,
  output logic [15:0] fault_thr,
  output logic [7:0] action,
  output logic [15:0] rdata,
  output logic rvalid
);

  typedef struct packed {
    logic [15:0] warn;
    logic [15:0] fault;
    logic [7:0] act;
    logic [15:0] rd;
    logic rv;
  } uvfh_regs_st_t;

  uvfh_regs_st_t s_reg, s_next;

  // ==========================================================
  // Register access
  always_comb begin
    s_next = s_reg;
    s_next.rv = req.rd;
    if (req.wr) begin
      unique case (req.cmd)
        UVFH_OFS_WARN: s_next.warn = req.wdata;
        UVFH_OFS_FAULT: s_next.fault = req.wdata;
        UVFH_OFS_ACTION: s_next.act = req.wdata[7:0];
        default: ;
      endcase
    end
    if (req.rd) begin
      unique case (req.cmd)
        UVFH_OFS_WARN: s_next.rd = s_reg.warn;
        UVFH_OFS_FAULT: s_next.rd = s_reg.fault;
        UVFH_OFS_ACTION: s_next.rd = {8'h00, s_reg.act};
        default: s_next.rd = 16'h0000;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      s_reg <= '{warn: UVFH_RST_WARN, fault: UVFH_RST_FAULT, act: UVFH_RST_ACTION,
                 rd: 16'h0000, rv: 1'b0};
    end else begin
      s_reg <= s_next;
    end
  end

  assign warn_thr = s_reg.warn;
  assign fault_thr = s_reg.fault;
  assign action = s_reg.act;
  assign rdata = s_reg.rd;
  assign rvalid = s_reg.rv;

  chk_write_warn: assert property (@(posedge clk) disable iff (rst)
    req.wr && req.cmd == UVFH_OFS_WARN |=> warn_thr == $past(req.wdata))
    else $error("warning threshold not written");
  chk_write_fault: assert property (@(posedge clk) disable iff (rst)
    req.wr && req.cmd == UVFH_OFS_FAULT |=> fault_thr == $past(req.wdata))
    else $error("fault threshold not written");

endmodule
`default_nettype wire

// file: uvfh_timer.sv
/*
  Delay timer: counts 2^n time units of a programmable length.
  Assumes unit length in clocks comes from the time unit register outside.
*/
`timescale 1ns/1ns
`default_nettype none
module uvfh_timer
  import uvfh_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic start,
  input wire logic [2:0] dly_code,
  input wire logic [UVFH_UNIT_W-1:0] unit_clks,
  output logic done
);

  typedef struct packed {
    logic busy;
    logic [UVFH_TMR_W-1:0] cnt;
    logic dn;
  } uvfh_tmr_st_t;

  uvfh_tmr_st_t s_reg, s_next;
  logic [UVFH_TMR_W-1:0] total;
  logic [UVFH_UNIT_W-1:0] unit_min;

  // ==========================================================
  // 2^n units, unit at least one clock
  assign unit_min = (unit_clks == '0) ? UVFH_UNIT_W'(1) : unit_clks;
  assign total = UVFH_TMR_W'({8'h00, unit_min} << dly_code);

  always_comb begin
    s_next = s_reg;
    s_next.dn = 1'b0;
    if (start) begin
      s_next.busy = 1'b1;
      s_next.cnt = total - UVFH_TMR_W'(1);
    end else if (s_reg.busy) begin
      if (s_reg.cnt == '0) begin
        s_next.busy = 1'b0;
        s_next.dn = 1'b1;
      end else begin
        s_next.cnt = s_reg.cnt - UVFH_TMR_W'(1);
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  assign done = s_reg.dn;

  chk_timer_len: assert property (@(posedge clk) disable iff (rst)
    start && dly_code == 3'h0 && unit_clks == 16'h0001 |=> ##1 done)
    else $error("one-unit delay length wrong");

endmodule
`default_nettype wire

// file: uvfh_host.sv
/*
  Host model: register writes and reads, clear and off requests.
  Assumes the block samples its command inputs at the rising clock edge.
*/
`timescale 1ns/1ns
`default_nettype none
module uvfh_host
  import uvfh_pkg::*;
(
  input wire logic clk,
  output logic cmd_wr,
  output logic cmd_rd,
  output logic [7:0] cmd_code,
  output logic [15:0] cmd_wdata,
  input wire logic [15:0] cmd_rdata,
  input wire logic cmd_rvalid,
  output logic clear_status,
  output logic clear_all,
  output logic cmd_off
);
  // ==========================================================
  // Idle levels
  initial begin
    cmd_wr = 1'b0;
    cmd_rd = 1'b0;
    cmd_code = 8'h00;
    cmd_wdata = 16'h0000;
    clear_status = 1'b0;
    clear_all = 1'b0;
    cmd_off = 1'b0;
  end

  // ==========================================================
  // Accesses
  // Released data line shows the inverse, never the last word
  task automatic wr(input logic [7:0] code, input logic [15:0] data);
    @(posedge clk);
    cmd_wr <= 1'b1;
    cmd_code <= code;
    cmd_wdata <= data;
    @(posedge clk);
    cmd_wr <= 1'b0;
    cmd_wdata <= ~data;
  endtask

  task automatic rd(input logic [7:0] code, output logic [15:0] data, output logic ok);
    ok = 1'b0;
    data = 16'h0000;
    @(posedge clk);
    cmd_rd <= 1'b1;
    cmd_code <= code;
    @(posedge clk);
    cmd_rd <= 1'b0;
    for (int i = 0; i < 3; i++) begin
      #1;
      if (cmd_rvalid === 1'b1) begin
        ok = 1'b1;
        data = cmd_rdata;
        break;
      end
      @(posedge clk);
    end
  endtask

  // Kind 0 status clear, 1 clear-all, else off then on
  task automatic clr(input int kind);
    @(posedge clk);
    case (kind)
      0: clear_status <= 1'b1;
      1: clear_all <= 1'b1;
      default: cmd_off <= 1'b1;
    endcase
    repeat (3) @(posedge clk);
    clear_status <= 1'b0;
    clear_all <= 1'b0;
    cmd_off <= 1'b0;
  endtask
endmodule
`default_nettype wire

// file: output_undervoltage_fault_handling_bench.sv
/*
  Self-checking bench for the undervoltage block.
  Assumes the host model drives the command side; measurements come from here.
*/
`timescale 1ns/1ns
`default_nettype none
module output_undervoltage_fault_handling_bench
  import uvfh_pkg::*;
;
  localparam logic [15:0] WARN_V = 16'h0B00;
  localparam logic [15:0] FAULT_V = 16'h0A00;
  localparam logic [15:0] LOW_V = 16'h0900;
  localparam logic [15:0] MID_V = 16'h0A80;
  localparam logic [15:0] GOOD_V = 16'h0C00;
  logic clk, sys_rst, ctrl_pin_off, meas_valid, en_q;
  logic cmd_wr, cmd_rd, clear_status, clear_all, cmd_off, cmd_rvalid;
  logic out_enable, uv_warn, uv_fault, uv_latched;
  logic [7:0] cmd_code;
  logic [15:0] cmd_wdata, cmd_rdata, meas_vout;
  logic [UVFH_UNIT_W-1:0] unit_clks;
  logic [2:0] tries [4] = '{3'h0, 3'h1, 3'h4, 3'h7};
  int ckind [4] = '{0, 3, 1, 2};
  int err_count = 0;
  int n_compared = 0;
  int rises = 0;
  int gap = 0;
  int cyc = 0;
  int last = 0;
  int base;

  uvfh_top dut (.CLK(clk), .SYS_RST(sys_rst), .CMD_WR(cmd_wr), .CMD_RD(cmd_rd),
    .CMD_CODE(cmd_code), .CMD_WDATA(cmd_wdata), .CMD_RDATA(cmd_rdata),
    .CMD_RVALID(cmd_rvalid), .CLEAR_STATUS(clear_status), .CLEAR_ALL(clear_all),
    .CMD_OFF(cmd_off), .CTRL_PIN_OFF(ctrl_pin_off), .UNIT_CLKS(unit_clks),
    .MEAS_VALID(meas_valid), .MEAS_VOUT(meas_vout), .OUT_ENABLE(out_enable),
    .UV_WARN(uv_warn), .UV_FAULT(uv_fault), .UV_LATCHED(uv_latched));
  uvfh_host host (.clk(clk), .cmd_wr(cmd_wr), .cmd_rd(cmd_rd), .cmd_code(cmd_code),
    .cmd_wdata(cmd_wdata), .cmd_rdata(cmd_rdata), .cmd_rvalid(cmd_rvalid),
    .clear_status(clear_status), .clear_all(clear_all), .cmd_off(cmd_off));

  // ==========================================================
  // Clock, watchdog, restart counter
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  initial begin
    #(4 * 10000);
    err_count++;
    $display("unexpected run length expected done seen hang");
    end_of_test();
  end
  always @(posedge clk) begin
    if (out_enable === 1'b1 && en_q === 1'b0) begin
      rises <= rises + 1;
      gap <= cyc - last;
      last <= cyc;
    end
    en_q <= out_enable;
    cyc <= cyc + 1;
  end

  // ==========================================================
  // Helpers
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    n_compared++;
    if (got !== exp) begin
      err_count++;
      $display("unexpected %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic rdchk(input logic [7:0] code, input logic [15:0] exp);
    logic [15:0] d;
    logic ok;
    host.rd(code, d, ok);
    chk("read valid", 16'h0001, {15'h0000, ok});
    chk("read data", exp, d);
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic act(input logic [7:0] a);
    host.wr(UVFH_OFS_ACTION, {8'h00, a});
  endtask
  // Pulse a measurement, or leave it streaming when hold is set
  task automatic meas(input logic [15:0] v, input logic hold);
    @(posedge clk);
    meas_valid <= 1'b1;
    meas_vout <= v;
    if (!hold) begin
      @(posedge clk);
      meas_valid <= 1'b0;
      meas_vout <= ~v;
    end
  endtask
  task automatic wait_en(input logic v, input int n);
    for (int i = 0; i <= n; i++) begin
      #1;
      if (out_enable === v) break;
      @(posedge clk);
    end
    chk("out_enable", {15'h0000, v}, {15'h0000, out_enable});
  endtask
  task automatic hold_en(input logic v, input int n);
    repeat (n) begin
      @(posedge clk);
      #1;
      chk("out_enable held", {15'h0000, v}, {15'h0000, out_enable});
    end
  endtask
  task automatic end_of_test();
    $display("compared %0d mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  // ==========================================================
  // Tests
  initial begin
    sys_rst = 1'b1;
    ctrl_pin_off = 1'b0;
    meas_valid = 1'b0;
    meas_vout = GOOD_V;
    unit_clks = 16'h0002;
    tick(4);
    sys_rst <= 1'b0;
    rdchk(UVFH_OFS_WARN, 16'h0000);
    rdchk(UVFH_OFS_FAULT, 16'h0000);
    rdchk(UVFH_OFS_ACTION, 16'h0000);
    host.wr(UVFH_OFS_WARN, WARN_V);
    host.wr(UVFH_OFS_FAULT, FAULT_V);
    host.wr(UVFH_OFS_ACTION, 16'hFF5A);
    host.wr(8'h46, 16'h1234);
    rdchk(UVFH_OFS_WARN, WARN_V);
    rdchk(UVFH_OFS_FAULT, FAULT_V);
    rdchk(UVFH_OFS_ACTION, 16'h005A);
    rdchk(8'h46, 16'h0000);
    // Ignore response, warning flag
    act(8'h00);
    meas(MID_V, 1'b0);
    tick(1);
    #1;
    chk("uv_warn", 16'h0001, {15'h0000, uv_warn});
    chk("uv_fault", 16'h0000, {15'h0000, uv_fault});
    meas(LOW_V, 1'b1);
    hold_en(1'b1, 20);
    chk("uv_fault", 16'h0001, {15'h0000, uv_fault});
    chk("uv_latched", 16'h0000, {15'h0000, uv_latched});
    meas(GOOD_V, 1'b0);
    host.clr(0);
    #1;
    chk("uv_warn", 16'h0000, {15'h0000, uv_warn});
    // Off only while the fault lasts
    act(8'hC0);
    meas(LOW_V, 1'b0);
    wait_en(1'b0, 2);
    hold_en(1'b0, 10);
    meas(GOOD_V, 1'b0);
    wait_en(1'b1, 2);
    // Ride through 4 units of 2 clocks per code step 2
    act(8'h42);
    meas(LOW_V, 1'b0);
    hold_en(1'b1, 7);
    wait_en(1'b0, 4);
    chk("uv_latched", 16'h0001, {15'h0000, uv_latched});
    meas(GOOD_V, 1'b0);
    host.clr(1);
    wait_en(1'b1, 20);
    meas(LOW_V, 1'b0);
    meas(GOOD_V, 1'b0);
    hold_en(1'b1, 20);
    // Shut and retry counts under a streaming fault
    @(posedge clk);
    unit_clks <= 16'h0003;
    for (int k = 0; k < 4; k++) begin
      act({2'h2, tries[k], 3'h1});
      base = rises;
      meas(LOW_V, 1'b1);
      wait_en(1'b0, 2);
      tick(300);
      if (k < 3) begin
        chk("restarts", {13'h0000, tries[k]}, 16'(rises - base));
        chk("uv_latched", 16'h0001, {15'h0000, uv_latched});
      end else begin
        chk("endless", 16'h0001, {15'h0000, (rises - base) >= 8});
        chk("uv_latched", 16'h0001, {15'h0000, uv_latched});
      end
      if (k >= 2) chk("spacing", 16'h0001, {15'h0000, gap >= 6 && gap <= 16});
      meas(GOOD_V, 1'b0);
      if (ckind[k] == 3) begin
        @(posedge clk);
        ctrl_pin_off <= 1'b1;
        tick(5);
        ctrl_pin_off <= 1'b0;
      end else host.clr(ckind[k]);
      wait_en(1'b1, 30);
      chk("uv_latched", 16'h0000, {15'h0000, uv_latched});
    end
    end_of_test();
  end
endmodule
`default_nettype wire
